// >>> dv/ascii_single_drop_cmd_parser_bench.sv
// Purpose: Self-checking bench for the interpreter
// Assumes: Short second count for the timeout
// Notes: Results checked in order from one queue
`timescale 1ns/100ps
module ascii_single_drop_cmd_parser_bench;
  import asd_pkg::*;
  logic sys_clk = 0, rst = 1, rx_valid = 0, slow = 0, paused = 0;
  logic [7:0] rx_data = 8'h00, tx_data;
  logic tx_valid, tx_ready, panel_blank, panel_event;
  logic time_set_valid, cmd_error, comm_timeout;
  logic [15:0] active_panel;
  logic [47:0] time_set;
  logic [47:0] expq[$];
  int num_errors = 0, comparisons = 0;
  always #2.5 sys_clk = ~sys_clk;
  asd_cmd_parser #(.TIMEOUT_SEC(2), .SEC_CYC(100)) DUT (
    .sys_clk(sys_clk), .rst(rst), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .active_panel(active_panel),
    .panel_blank(panel_blank), .panel_event(panel_event),
    .time_set(time_set), .time_set_valid(time_set_valid),
    .cmd_error(cmd_error), .comm_timeout(comm_timeout));
  asd_host host (.sys_clk(sys_clk), .slow(slow), .tx_ready(tx_ready));
  task check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Empty queue gives a note that no result can match
  function automatic logic [47:0] pop_exp();
    if (expq.size() == 0)
      return 48'hffff_ffff_ffff;
    return expq.pop_front();
  endfunction
  // One byte per cycle; pause state follows flow bytes
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_data = s[i];
      rx_valid = 1'b1;
      @(posedge sys_clk);
      #1;
      if (s[i] == CH_XOFF) paused = 1'b1;
      if (s[i] == CH_XON) paused = 1'b0;
    end
    rx_valid = 1'b0;
    // One idle edge so a following call never re-raises valid at once
    @(posedge sys_clk);
    #1;
  endtask
  task end_test(input string name);
    for (int i = 0; i < 400 && expq.size() > 0; i++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
    #1;
    check(48'(expq.size()), 48'h0);
    $display("test %s done", name);
  endtask
  task stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Takes the oldest note whenever a result shows
  always @(posedge sys_clk) begin
    if (!rst && panel_event)
      check({31'h0, panel_blank, active_panel}, pop_exp());
    if (!rst && time_set_valid)
      check(time_set, pop_exp());
    if (!rst && cmd_error)
      check(48'he0, pop_exp());
    if (!rst && comm_timeout)
      check(48'h7e0, pop_exp());
    if (!rst && tx_valid && tx_ready && !paused)
      check(48'(tx_data), pop_exp());
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
  initial begin
    int p, v;
    string s;
    void'($urandom(32'h06d1b5d1));
    repeat (20) @(posedge sys_clk);
    #1 rst = 0;
    p = $urandom_range(1, 9999);
    expq = '{48'h8, 48'(p)};
    send({"\x148\x0d\x14", $sformatf("%0d", p), "\x0d"});
    end_test("trigger");
    expq = '{48'h10000};
    send({"\x15", $sformatf("%0d", p), "\x0d"});
    end_test("untrigger");
    expq = '{48'he0, 48'he0, 48'h3};
    send("A12\x0d\x1663,A\x0d\x143\x0d");
    end_test("bad lead");
    s = "\x14";
    repeat (997) s = {s, "0"};
    expq = '{48'h7, 48'he0};
    send({s, "7\x0d", s, "1111\x0d"});
    end_test("length");
    expq = '{48'h070e5e023700};
    send("\x0c07,14,94,02,55,00\x0d");
    end_test("time");
    v = $urandom_range(0, 255);
    send({"\x1663,", $sformatf("%0d", v), ",6\x0d"});
    expq = '{48'h12, 48'(v), 48'h2c, 48'h6, 48'h2c, 48'h0d};
    slow = 1;
    send("\x1263,3\x0d");
    end_test("read");
    slow = 0;
    expq = '{48'h12, 48'(v), 48'h0d};
    send("\x13\x1263,1\x0d");
    repeat (30) @(posedge sys_clk);
    #1;
    check(48'(expq.size()), 48'h3);
    send("\x11");
    end_test("flow");
    expq = '{48'h7e0};
    send("\x14");
    repeat (260) @(posedge sys_clk);
    end_test("timeout");
    stop_test();
  end
endmodule
bind asd_cmd_parser asd_cmd_parser_sva chk (
  .sys_clk(sys_clk), .rst(rst), .rx_data(rx_data),
  .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .tx_valid(tx_valid), .active_panel(active_panel),
  .panel_blank(panel_blank), .panel_event(panel_event),
  .time_set(time_set), .time_set_valid(time_set_valid),
  .cmd_error(cmd_error), .comm_timeout(comm_timeout));

// >>> dv/asd_cmd_parser_sva.sv
// Purpose: Port checks for the command interpreter
// Assumes: Bound onto asd_cmd_parser by the bench
// Notes: Tracks lead byte and pause state as helpers
`timescale 1ns/100ps
module asd_cmd_parser_sva
  import asd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic [15:0] active_panel,
  input wire logic panel_blank,
  input wire logic panel_event,
  input wire logic [47:0] time_set,
  input wire logic time_set_valid,
  input wire logic cmd_error,
  input wire logic comm_timeout
);
  logic first, paused, next_first, next_paused;
  logic [7:0] lead, next_lead;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Flow bytes never start a command
  always_comb begin
    next_first = first;
    next_paused = paused;
    next_lead = lead;
    if (rx_valid && rx_data == CH_XOFF) next_paused = 1'b1;
    else if (rx_valid && rx_data == CH_XON) next_paused = 1'b0;
    else if (rx_valid) begin
      next_first = rx_data == CH_CR;
      if (first) next_lead = rx_data;
    end
  end
  // Helper registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first <= 1'b1;
      paused <= 1'b0;
      lead <= 8'h00;
    end else begin
      first <= next_first;
      paused <= next_paused;
      lead <= next_lead;
    end
  end
  a_event_after_cr: assert property (panel_event
    |-> $past(rx_valid && rx_data == CH_CR))
    else $error("panel event without carriage return");
  a_event_lead: assert property (panel_event
    |-> lead == CH_TRIG || lead == CH_UNTRIG)
    else $error("panel event from wrong command");
  a_trig_shows: assert property (panel_event && !panel_blank
    |-> active_panel != NO_PANEL)
    else $error("triggered panel not shown");
  a_panel_hold: assert property (!panel_event
    |-> $stable(active_panel) && $stable(panel_blank))
    else $error("panel changed on its own");
  a_blank_none: assert property (panel_blank
    |-> active_panel == NO_PANEL)
    else $error("blank display names a panel");
  a_time_lead: assert property (time_set_valid
    |-> $past(rx_valid && rx_data == CH_CR) && lead == CH_TIME)
    else $error("time set without time command");
  a_read_head: assert property (rx_valid && rx_data == CH_CR
    && lead == CH_READ && !first && !tx_valid
    |=> tx_valid && tx_data == CH_READ)
    else $error("read answer does not start");
  a_tx_hold: assert property (tx_valid && (!tx_ready || paused)
    |=> tx_valid && $stable(tx_data))
    else $error("tx byte lost while held");
  a_err_pulse: assert property (cmd_error |=> !cmd_error)
    else $error("error pulse too long");
  a_tout_pulse: assert property (comm_timeout |=> !comm_timeout)
    else $error("timeout pulse too long");
endmodule

// >>> dv/asd_host.sv
// Purpose: Host side UART sink for the interpreter
// Assumes: Bench seeds the random generator
// Notes: Slow mode stalls at random
`timescale 1ns/100ps
module asd_host (
  input wire logic sys_clk,
  input wire logic slow,
  output logic tx_ready = 1'b0
);
  // Random stalls prove the byte is held, not dropped
  always @(posedge sys_clk) begin
    tx_ready <= #1 slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
endmodule

// >>> rtl/asd_cmd_parser.sv
// Purpose: Command interpreter for the ASCII single-drop protocol
// Assumes: Bytes arrive from a UART on sys_clk with a valid strobe
// Notes: Integer variables only in the store; strings not held here
`timescale 1ns/100ps
// Functional notes
// - Carriage return ends every command
// - 0x14 plus digits triggers a panel
// - Triggered panel becomes the active screen
// - 0x15 plus digits untriggers a panel
// - Untrigger leaves display blank, no substitute
// - Variable identifiers valid from 1 to 9999; the store keeps only 1 to NUM_VARS, at most 5000
// - Commands up to 1000 characters accepted
// - Strings hold zero to 127 characters; no strings are stored here, text in a field is a cmd_error
// - One string per read or write command; here reads and writes carry integers only
// - XON/XOFF pauses and resumes transmission
// - Link runs 9600 baud, 8N1, no handshake
// - Storage at most 10,000 words in total
// - Integers saturate at plus/minus 999,999,999
// - Timeout configurable in whole seconds
// - 0x12 id,count reads; answers comma list
// - Missing variable answers an empty field
// - 0x16 id then values writes consecutively
// - 0x0c sets month,day,year,hour,min,sec
module asd_cmd_parser
  import asd_pkg::*;
#(
  parameter int NUM_VARS = 64,
  parameter int TIMEOUT_SEC = 5,
  parameter int SEC_CYC = SEC_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic [15:0] active_panel,
  output logic panel_blank,
  output logic panel_event,
  output logic [47:0] time_set,
  output logic time_set_valid,
  output logic cmd_error,
  output logic comm_timeout
);
  localparam int VW = $clog2(NUM_VARS);
  asd_state_e state, next_state;
  logic [7:0] cmd, next_cmd;
  logic [9:0] len, next_len;
  logic [2:0] fld, next_fld;
  logic signed [31:0] arg0, next_arg0;
  logic [13:0] idx, next_idx;
  logic [13:0] cnt, next_cnt;
  logic tx_paused, next_tx_paused;
  logic [47:0] next_time_set;
  logic next_time_set_valid, next_panel_event, next_cmd_error;
  logic [15:0] next_active_panel;
  logic next_panel_blank;
  logic signed [31:0] mem [NUM_VARS];
  logic [NUM_VARS-1:0] present, next_present;
  logic we;
  logic [VW-1:0] waddr;
  logic [7:0] next_tx_data;
  logic next_tx_valid;
  logic [31:0] tmo, next_tmo;
  logic acc_clear, acc_load, acc_seen, acc_bad;
  logic signed [31:0] acc_val;
  logic byte_in, is_digit_end, is_sep;

  // Shared test: identifier inside the protocol range and the store
  function automatic logic id_ok(input logic [13:0] id);
    id_ok = id >= 14'(VAR_ID_MIN) && id <= 14'(VAR_ID_MAX)
      && id <= 14'(STORE_WORDS / 2)
      && id <= 14'(NUM_VARS);
  endfunction

  asd_dec_acc u_acc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(acc_clear),
    .load(acc_load),
    .ch(rx_data),
    .value(acc_val),
    .seen(acc_seen),
    .bad(acc_bad)
  );

  // Flow-control bytes are consumed here and never parsed
  assign byte_in = rx_valid && rx_data != CH_XON
    && rx_data != CH_XOFF;
  assign is_digit_end = byte_in && rx_data == CH_CR;
  assign is_sep = byte_in && rx_data == CH_COMMA;
  assign acc_load = byte_in && state == ASD_FIELD && !is_digit_end
    && !is_sep;
  assign acc_clear = (byte_in && state == ASD_IDLE) || is_sep;

  // Main parse and response sequencing
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_len = len;
    next_fld = fld;
    next_arg0 = arg0;
    next_idx = idx;
    next_cnt = cnt;
    next_present = present;
    next_time_set = time_set;
    next_time_set_valid = 1'b0;
    next_panel_event = 1'b0;
    next_cmd_error = 1'b0;
    next_active_panel = active_panel;
    next_panel_blank = panel_blank;
    next_tx_data = tx_data;
    next_tx_valid = tx_valid && !(tx_ready && !tx_paused);
    we = 1'b0;
    waddr = '0;
    if (rx_valid && rx_data == CH_XOFF)
      next_tx_paused = 1'b1;
    else if (rx_valid && rx_data == CH_XON)
      next_tx_paused = 1'b0;
    else
      next_tx_paused = tx_paused;
    if (byte_in)
      next_len = (len == 10'(MAX_CMD_LEN)) ? len : len + 10'd1;
    case (state)
      ASD_IDLE: begin
        if (byte_in) begin
          next_cmd = rx_data;
          next_fld = '0;
          next_len = 10'd1;
          if (rx_data == CH_TRIG || rx_data == CH_UNTRIG
              || rx_data == CH_READ || rx_data == CH_WRITE
              || rx_data == CH_TIME)
            next_state = ASD_FIELD;
          else if (rx_data != CH_CR) begin
            next_state = ASD_SKIP;
            next_cmd_error = 1'b1;
          end
        end
      end
      ASD_FIELD: begin
        if (acc_bad || (byte_in && len >= 10'(MAX_CMD_LEN)
            && !is_digit_end)) begin
          // Text in a value field lands here: no string store. A bad
          // byte right before the CR must not swallow the next command
          next_state = is_digit_end ? ASD_IDLE : ASD_SKIP;
          next_cmd_error = 1'b1;
        end else if (is_sep || is_digit_end) begin
          next_fld = (fld == 3'd7) ? fld : fld + 3'd1; // Sticks, no wrap
          if (fld == 3'd0)
            next_arg0 = acc_val;
          if (cmd == CH_WRITE && fld != 3'd0) begin
            // Values land on consecutive variables; gaps skipped
            if (id_ok(idx) && acc_seen) begin
              we = 1'b1;
              waddr = VW'(idx - 14'd1);
              next_present[waddr] = 1'b1;
            end
            next_idx = idx + 14'd1;
          end
          if (cmd == CH_WRITE && fld == 3'd0)
            next_idx = acc_val[13:0];
          if (cmd == CH_TIME && fld < 3'(TIME_FIELDS))
            next_time_set[8*(5-fld) +: 8] = acc_val[7:0];
          if (is_digit_end) begin
            next_state = ASD_IDLE;
            if (!acc_seen && fld == 3'd0 && cmd != CH_WRITE)
              next_cmd_error = 1'b1;
            else if (cmd == CH_TRIG) begin
              next_active_panel = acc_val[15:0];
              next_panel_blank = 1'b0;
              next_panel_event = 1'b1;
            end else if (cmd == CH_UNTRIG) begin
              if (active_panel == acc_val[15:0]) begin
                next_active_panel = NO_PANEL;
                next_panel_blank = 1'b1;
              end
              next_panel_event = 1'b1;
            end else if (cmd == CH_TIME) begin
              if (fld == 3'(TIME_FIELDS - 1))
                next_time_set_valid = 1'b1;
              else
                next_cmd_error = 1'b1;
            end else if (cmd == CH_READ) begin
              next_idx = (fld == 3'd0) ? acc_val[13:0]
                : arg0[13:0];
              next_cnt = (fld == 3'd1) ? acc_val[13:0] : 14'd1;
              next_state = ASD_RESP;
              next_tx_data = CH_READ;
              next_tx_valid = 1'b1;
            end
          end
        end
      end
      ASD_SKIP: begin
        if (is_digit_end)
          next_state = ASD_IDLE;
      end
      ASD_RESP: begin
        // One byte per value: low byte only, though the store keeps 32 bits
        if (!tx_valid || (tx_ready && !tx_paused)) begin
          if (cnt == 14'd0) begin
            next_tx_data = CH_CR;
            next_tx_valid = 1'b1;
            next_state = ASD_IDLE;
          end else begin
            next_state = ASD_RVAL;
            if (id_ok(idx) && present[VW'(idx - 14'd1)]) begin
              next_tx_data = mem[VW'(idx - 14'd1)][7:0];
              next_tx_valid = 1'b1;
            end
            // Missing identifier: nothing sent, empty field
          end
        end
      end
      ASD_RVAL: begin
        if (!tx_valid || (tx_ready && !tx_paused)) begin
          next_idx = idx + 14'd1;
          next_cnt = cnt - 14'd1;
          next_state = ASD_RESP;
          if (cnt != 14'd1) begin
            next_tx_data = CH_COMMA;
            next_tx_valid = 1'b1;
          end
        end
      end
      default: next_state = ASD_IDLE;
    endcase
  end

  // Inactivity timer in whole seconds while a command is half received;
  // response states may wait on XOFF for as long as the host likes
  always_comb begin
    next_tmo = tmo;
    comm_timeout = 1'b0;
    if (!(state == ASD_FIELD || state == ASD_SKIP) || byte_in)
      next_tmo = '0;
    else if (tmo == 32'(TIMEOUT_SEC * SEC_CYC)) begin
      comm_timeout = 1'b1;
      next_tmo = '0;
    end else
      next_tmo = tmo + 32'd1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ASD_IDLE;
      cmd <= '0;
      len <= '0;
      fld <= '0;
      arg0 <= '0;
      idx <= '0;
      cnt <= '0;
      present <= '0;
      tx_paused <= 1'b0;
      time_set <= '0;
      time_set_valid <= 1'b0;
      panel_event <= 1'b0;
      cmd_error <= 1'b0;
      active_panel <= NO_PANEL;
      panel_blank <= 1'b1;
      tx_data <= '0;
      tx_valid <= 1'b0;
      tmo <= '0;
    end else begin
      // Timeout abandons a half command
      state <= comm_timeout ? ASD_IDLE : next_state;
      cmd <= next_cmd;
      len <= next_len;
      fld <= next_fld;
      arg0 <= next_arg0;
      idx <= next_idx;
      cnt <= next_cnt;
      present <= next_present;
      tx_paused <= next_tx_paused;
      time_set <= next_time_set;
      time_set_valid <= next_time_set_valid;
      panel_event <= next_panel_event;
      cmd_error <= next_cmd_error;
      active_panel <= next_active_panel;
      panel_blank <= next_panel_blank;
      tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;
      tmo <= next_tmo;
    end
  end

  // Variable store, no reset so it maps to RAM
  always_ff @(posedge sys_clk) begin
    if (we)
      mem[waddr] <= acc_val;
  end
endmodule

// >>> rtl/asd_dec_acc.sv
// Purpose: Signed decimal accumulator for one comma field
// Assumes: Digits arrive one per cycle with a strobe
// Notes: Saturates at the integer limit, flags any bad character
`timescale 1ns/100ps
module asd_dec_acc
  import asd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] ch,
  output logic signed [31:0] value,
  output logic seen,
  output logic bad
);
  logic [31:0] mag;
  logic neg;
  logic [31:0] next_mag;
  logic next_neg;
  logic next_seen;
  logic next_bad;
  logic [35:0] prod;

  // Accumulate digits; saturating keeps wide values in range
  always_comb begin
    next_mag = mag;
    next_neg = neg;
    next_seen = seen;
    next_bad = bad;
    prod = 36'(mag) * 36'd10 + 36'(ch - CH_ZERO);
    if (clear) begin
      next_mag = '0;
      next_neg = 1'b0;
      next_seen = 1'b0;
      next_bad = 1'b0;
    end else if (load) begin
      if (ch >= CH_ZERO && ch <= 8'h39) begin
        next_seen = 1'b1;
        if (prod > 36'(INT_MAX))
          next_mag = 32'(INT_MAX);
        else
          next_mag = prod[31:0];
      end else if (ch == CH_MINUS && !seen && !neg) begin
        next_neg = 1'b1;
      end else if (ch != CH_SPACE) begin
        next_bad = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mag <= '0;
      neg <= 1'b0;
      seen <= 1'b0;
      bad <= 1'b0;
    end else begin
      mag <= next_mag;
      neg <= next_neg;
      seen <= next_seen;
      bad <= next_bad;
    end
  end

  assign value = neg ? -$signed(mag) : $signed(mag);
endmodule

// >>> rtl/asd_pkg.sv
// Purpose: Constants for the ASCII single-drop command interpreter
// Assumes: Byte stream from a UART on the system clock
// Notes: Codes, limits and timing counts live here, but for NUM_VARS, TIMEOUT_SEC and 8'h39 in asd_dec_acc
package asd_pkg;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_TRIG = 8'h14;
  localparam logic [7:0] CH_UNTRIG = 8'h15;
  localparam logic [7:0] CH_READ = 8'h12;
  localparam logic [7:0] CH_WRITE = 8'h16;
  localparam logic [7:0] CH_TIME = 8'h0c;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam int MAX_CMD_LEN = 1000;
  localparam int MAX_STR_LEN = 127;
  localparam int VAR_ID_MIN = 1;
  localparam int VAR_ID_MAX = 9999;
  localparam int STORE_WORDS = 10000;
  localparam int INT_MAX = 999999999;
  localparam int TIME_FIELDS = 6;
  localparam int CLK_HZ = 200000000;
  localparam int BAUD = 9600;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam logic [15:0] NO_PANEL = 16'h0000;
  typedef enum logic [2:0] {
    ASD_IDLE = 3'b000,
    ASD_FIELD = 3'b001,
    ASD_SKIP = 3'b010,
    ASD_RESP = 3'b011,
    ASD_RVAL = 3'b100
  } asd_state_e;
endpackage
